// ===== src/cpmbt_regs.svh
`ifndef CPMBT_REGS_SVH
`define CPMBT_REGS_SVH
// Register indices; the APB byte address is four times the index.
`define CPMBT_IDX_CTRL0 7'h00
`define CPMBT_IDX_CTRL1 7'h01
`define CPMBT_IDX_BT0 7'h02
`define CPMBT_IDX_BT1 7'h03
`define CPMBT_IDX_PEXT 7'h04
`define CPMBT_IDX_FILT 4'h2
`define CPMBT_IDX_RXBUF 3'h4
`define CPMBT_TXBUF_BASE 6'h10
// Field positions.
`define CPMBT_C0_SRST 0
`define CPMBT_C0_SLEEP_REQUEST 1
`define CPMBT_C0_SLEEP_ACKNOWLEDGE 2
`define CPMBT_C0_TLNK 3
`define CPMBT_C0_SYNC 4
`define CPMBT_C1_CLOCK_SOURCE_SELECT 0
`define CPMBT_C1_WAKE_FILTER_MODE 1
`define CPMBT_BT0_SJW 7:6
`define CPMBT_BT0_PRESC 5:0
`define CPMBT_BT1_TRIPLE 7
`define CPMBT_BT1_SEG2 6:4
`define CPMBT_BT1_SEG1 3:0
`define CPMBT_PEXT_PRESC 1:0
// Reset values.
`define CPMBT_RST_CTRL0 8'h01
`define CPMBT_RST_CTRL1 8'h00
`define CPMBT_RST_BT0 8'h00
`define CPMBT_RST_BT1 8'h00
`define CPMBT_RST_PEXT 2'h0
// Timing.
`define CPMBT_IDLE_BITS 4'hb
`define CPMBT_CLK_MHZ 20
`define CPMBT_WAKE_FILT_NS 500
`define CPMBT_WAKE_FILT_CYC ((`CPMBT_WAKE_FILT_NS * `CPMBT_CLK_MHZ + 999) / 1000)
`endif

// ===== src/cpmbt_pkg.sv
package cpmbt_pkg;
  typedef enum logic [1:0] {
    MODE_SOFT = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_RUN = 2'b11,
    MODE_SLEEP = 2'b10
  } cpmbt_mode_e;
  typedef struct packed {
    logic [7:0] presc;
    logic [1:0] resync_jump_width;
    logic [3:0] seg1;
    logic [2:0] seg2;
    logic triple;
  } cpmbt_timing_s;
endpackage

// ===== src/cpmbt_bit_timer.sv
`timescale 1ns/1ps
module cpmbt_bit_timer (
  input logic clock_in, // module clock
  input logic rst_in, // synchronous reset
  input logic enable_in, // run the bit clock
  input logic rx_in, // synchronised receive level
  input cpmbt_pkg::cpmbt_timing_s cfg_in, // bit timing fields
  output logic tx_point_out, // start of a bit
  output logic sample_point_out, // sample point
  output logic sample_bit_out // sampled value
);
  logic [7:0] presc_q;
  logic [4:0] idx_q, s1_end_q, last_q;
  logic [4:0] idx_d, s1_d, last_d, s1n, s2n, sjwn, base_last, e, e2;
  logic edge_q, rx_prev_q, tick, ext, newbit;
  logic [1:0] samp_q;

  assign tick = presc_q == cfg_in.presc;
  // Lengths are field plus one; fields below the legal range are clamped.
  assign s1n = {1'b0, (cfg_in.seg1 < 4'h3) ? 4'h3 : cfg_in.seg1} + 5'h01;
  assign s2n = {2'h0, (cfg_in.seg2 < 3'h1) ? 3'h1 : cfg_in.seg2} + 5'h01;
  assign sjwn = {3'h0, cfg_in.resync_jump_width} + 5'h01;
  assign base_last = s1n + s2n;
  assign e2 = last_q + 5'h01 - idx_q;

  always_ff @(posedge clock_in) begin
    if (rst_in || !enable_in || tick) begin
      presc_q <= 8'h00;
    end else begin
      presc_q <= presc_q + 8'h01;
    end
  end

  always_comb begin
    idx_d = idx_q;
    s1_d = s1_end_q;
    last_d = last_q;
    newbit = 1'b0;
    ext = 1'b0;
    e = (idx_q < sjwn) ? idx_q : sjwn;
    if (tick) begin
      if (edge_q && idx_q != 5'h00 && idx_q <= s1_end_q) begin
        // Late edge: stretch segment one by at most the jump width.
        ext = 1'b1;
        s1_d = s1_end_q + e;
        last_d = last_q + e;
        idx_d = idx_q + 5'h01;
      end else if (edge_q && idx_q > s1_end_q && e2 <= sjwn) begin
        newbit = 1'b1;
        idx_d = 5'h01;
        s1_d = s1n;
        last_d = base_last;
      end else if (edge_q && idx_q > s1_end_q) begin
        last_d = last_q - sjwn;
        if (idx_q >= last_d) begin
          newbit = 1'b1;
          idx_d = 5'h00;
          s1_d = s1n;
          last_d = base_last;
        end else begin
          idx_d = idx_q + 5'h01;
        end
      end else if (idx_q >= last_q) begin
        // Index 0 is the one-quantum sync segment.
        newbit = 1'b1;
        idx_d = 5'h00;
        s1_d = s1n;
        last_d = base_last;
      end else begin
        idx_d = idx_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || !enable_in) begin
      idx_q <= 5'h00;
      // The first bit after enable already runs on the programmed lengths.
      s1_end_q <= s1n;
      last_q <= base_last;
      edge_q <= 1'b0;
      rx_prev_q <= 1'b1;
      samp_q <= 2'h3;
    end else begin
      idx_q <= idx_d;
      s1_end_q <= s1_d;
      last_q <= last_d;
      rx_prev_q <= rx_in;
      // A new edge in a tick cycle is kept, not lost.
      edge_q <= tick ? (rx_prev_q & ~rx_in) : (edge_q | (rx_prev_q & ~rx_in));
      if (tick) begin
        samp_q <= {samp_q[0], rx_in};
      end
    end
  end

  assign tx_point_out = newbit;
  assign sample_point_out = tick & ~ext & (idx_q == s1_end_q);
  // Third sample is the one taken at the sample point.
  assign sample_bit_out = cfg_in.triple ?
    ((samp_q[1] & samp_q[0]) | (samp_q[1] & rx_in) | (samp_q[0] & rx_in)) : rx_in;
endmodule // cpmbt_bit_timer

// ===== src/cpmbt_top.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cpmbt_regs.svh"
module cpmbt_top #(
  parameter int ADDR_W = 12,
  parameter int WAKE_FILT_CYC = `CPMBT_WAKE_FILT_CYC
) (
  input logic clock_in, // module clock
  input logic rst_in, // synchronous reset, active high
  input logic psel_in, // APB select
  input logic penable_in, // APB enable
  input logic pwrite_in, // APB direction
  input logic [ADDR_W-1:0] paddr_in, // APB byte address
  input logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input logic stop_mode_in, // CPU in stop mode
  input logic can_rx_pin_in, // receive pin
  output logic can_tx_pin_out, // transmit pin
  input logic eng_tx_bit_in, // next bit from protocol engine
  input logic eng_busy_in, // engine mid-frame
  input logic eng_frame_ok_in, // valid end of frame pulse
  input logic eng_rx_we_in, // engine receive buffer write
  input logic [3:0] eng_rx_addr_in, // receive buffer byte
  input logic [7:0] eng_rx_data_in, // receive buffer data
  input logic [5:0] eng_tx_addr_in, // transmit buffers byte 0..47
  output logic [7:0] eng_tx_data_out, // transmit buffer data
  output logic eng_run_out, // engine may run
  output logic eng_bit_start_out, // bit start pulse
  output logic eng_sample_out, // sample point pulse
  output logic eng_rx_bit_out, // sampled bus bit
  output logic timer_b_ch0_out, // timer B channel 0 input
  output logic wake_mcu_out, // wake-up pulse
  output logic clock_source_out // 1 selects PLL clock
);
  ////////////////////////////////////////////////////////////////////////////////
  cpmbt_pkg::cpmbt_mode_e mode_q, mode_d;
  cpmbt_pkg::cpmbt_timing_s cfg;
  logic srst_q, sleep_request_q, tlnk_q, clock_source_select_q, wake_filter_mode_q;
  logic [7:0] bt0_q, bt1_q, rd_d;
  logic [1:0] pext_q;
  logic [7:0] filt_q [0:7];
  logic [7:0] buf_q [0:63];
  logic pready_q, pslverr_q, run_q, tx_q, pulse_q, tmr_q, wake_q, bs_q, smp_q, rxb_q;
  logic [31:0] prdata_q;
  logic [7:0] txd_q, wcnt_q, thr;
  logic [3:0] idle_cnt_q;
  logic rx_m_q, rx_s_q, bt_tx, bt_samp, bt_bit, bt_en, run_d, wake_hit;
  logic [6:0] idx;
  logic unmapped, acc_go, wr_ok, cfg_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave with one wait state; the whole map is 128 byte registers.
  assign idx = paddr_in[8:2];
  assign unmapped = paddr_in[ADDR_W-1:9] != '0;
  assign acc_go = psel_in & penable_in & ~pready_q;
  // Stop mode blocks even a write that is already mid-transfer.
  assign wr_ok = psel_in & penable_in & pready_q & pwrite_in & ~pslverr_q & ~stop_mode_in;
  assign cfg_wr = wr_ok & srst_q;

  always_comb begin
    rd_d = 8'h00;
    if (idx == `CPMBT_IDX_CTRL0) begin
      rd_d[`CPMBT_C0_SRST] = srst_q;
      rd_d[`CPMBT_C0_SLEEP_REQUEST] = sleep_request_q;
      rd_d[`CPMBT_C0_SLEEP_ACKNOWLEDGE] = mode_q == cpmbt_pkg::MODE_SLEEP;
      rd_d[`CPMBT_C0_TLNK] = tlnk_q;
      rd_d[`CPMBT_C0_SYNC] = mode_q == cpmbt_pkg::MODE_RUN;
    end else if (idx == `CPMBT_IDX_CTRL1) begin
      rd_d[`CPMBT_C1_CLOCK_SOURCE_SELECT] = clock_source_select_q;
      rd_d[`CPMBT_C1_WAKE_FILTER_MODE] = wake_filter_mode_q;
    end else if (idx == `CPMBT_IDX_BT0) begin
      rd_d = bt0_q;
    end else if (idx == `CPMBT_IDX_BT1) begin
      rd_d = bt1_q;
    end else if (idx == `CPMBT_IDX_PEXT) begin
      rd_d[`CPMBT_PEXT_PRESC] = pext_q;
    end else if (idx[6:3] == `CPMBT_IDX_FILT) begin
      rd_d = filt_q[idx[2:0]];
    end else if (idx[6]) begin
      rd_d = buf_q[idx[5:0]];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (acc_go) begin
      pready_q <= 1'b1;
      pslverr_q <= stop_mode_in | unmapped;
      prdata_q <= (stop_mode_in | unmapped) ? 32'h00000000 : {24'h000000, rd_d};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control 0 stays writable in every mode but power-down.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      srst_q <= 1'(`CPMBT_RST_CTRL0);
      sleep_request_q <= 1'b0;
      tlnk_q <= 1'b0;
    end else if (wr_ok && idx == `CPMBT_IDX_CTRL0) begin
      srst_q <= pwdata_in[`CPMBT_C0_SRST];
      tlnk_q <= pwdata_in[`CPMBT_C0_TLNK];
      // Sleep request can only be withdrawn once acknowledged; a set wins over a wake clear.
      if (pwdata_in[`CPMBT_C0_SLEEP_REQUEST] || mode_q == cpmbt_pkg::MODE_SLEEP) begin
        sleep_request_q <= pwdata_in[`CPMBT_C0_SLEEP_REQUEST];
      end
    end else if (wake_hit && mode_q == cpmbt_pkg::MODE_SLEEP) begin
      sleep_request_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clock_source_select_q <= 1'(`CPMBT_RST_CTRL1);
      wake_filter_mode_q <= 1'b0;
      bt0_q <= `CPMBT_RST_BT0;
      bt1_q <= `CPMBT_RST_BT1;
      pext_q <= `CPMBT_RST_PEXT;
    end else if (cfg_wr) begin
      if (idx == `CPMBT_IDX_CTRL1) begin
        clock_source_select_q <= pwdata_in[`CPMBT_C1_CLOCK_SOURCE_SELECT];
        wake_filter_mode_q <= pwdata_in[`CPMBT_C1_WAKE_FILTER_MODE];
      end
      if (idx == `CPMBT_IDX_BT0) begin
        bt0_q <= pwdata_in[7:0];
      end
      if (idx == `CPMBT_IDX_BT1) begin
        bt1_q <= pwdata_in[7:0];
      end
      if (idx == `CPMBT_IDX_PEXT) begin
        pext_q <= pwdata_in[`CPMBT_PEXT_PRESC];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < 8; i++) begin
        filt_q[i] <= 8'h00;
      end
    end else if (cfg_wr && idx[6:3] == `CPMBT_IDX_FILT) begin
      filt_q[idx[2:0]] <= pwdata_in[7:0];
    end
  end

  // The CPU may not write the receive buffer; the engine writes nothing else.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < 64; i++) begin
        buf_q[i] <= 8'h00;
      end
      txd_q <= 8'h00;
    end else begin
      if (wr_ok && idx[6] && idx[5:4] != 2'h0) begin
        buf_q[idx[5:0]] <= pwdata_in[7:0];
      end
      if (eng_rx_we_in) begin
        buf_q[{2'h0, eng_rx_addr_in}] <= eng_rx_data_in;
      end
      txd_q <= buf_q[eng_tx_addr_in + `CPMBT_TXBUF_BASE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode control.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cpmbt_pkg::MODE_SOFT: begin
        if (!srst_q) begin
          mode_d = cpmbt_pkg::MODE_WAIT;
        end
      end
      cpmbt_pkg::MODE_WAIT: begin
        if (sleep_request_q) begin
          mode_d = cpmbt_pkg::MODE_SLEEP;
        end else if (idle_cnt_q == `CPMBT_IDLE_BITS) begin
          mode_d = cpmbt_pkg::MODE_RUN;
        end
      end
      cpmbt_pkg::MODE_RUN: begin
        if (sleep_request_q && !eng_busy_in) begin
          mode_d = cpmbt_pkg::MODE_SLEEP;
        end
      end
      cpmbt_pkg::MODE_SLEEP: begin
        if (!sleep_request_q || wake_hit) begin
          mode_d = cpmbt_pkg::MODE_WAIT;
        end
      end
      default: mode_d = cpmbt_pkg::MODE_SOFT;
    endcase
    // Stop drops a running link back to idle search so that leaving it resynchronises.
    if (stop_mode_in && mode_d == cpmbt_pkg::MODE_RUN) begin
      mode_d = cpmbt_pkg::MODE_WAIT;
    end
    if (srst_q) begin
      mode_d = cpmbt_pkg::MODE_SOFT;
    end
  end

  // CPU wait is deliberately absent here: the controller keeps running through it.
  assign run_d = mode_d == cpmbt_pkg::MODE_RUN;
  assign bt_en = (mode_q == cpmbt_pkg::MODE_WAIT || mode_q == cpmbt_pkg::MODE_RUN) && !stop_mode_in;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_q <= cpmbt_pkg::MODE_SOFT;
      run_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and wake detection.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= can_rx_pin_in;
      rx_s_q <= rx_m_q;
    end
  end

  assign thr = wake_filter_mode_q ? 8'(WAKE_FILT_CYC) : 8'h01;
  assign wake_hit = (mode_q == cpmbt_pkg::MODE_SLEEP || stop_mode_in) && !srst_q && wcnt_q >= thr;

  always_ff @(posedge clock_in) begin
    if (rst_in || rx_s_q) begin
      wcnt_q <= 8'h00;
    end else if (wcnt_q != 8'hff) begin
      wcnt_q <= wcnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_hit && (wcnt_q == thr);
    end
  end

  // Recessive bit count while searching for bus idle.
  always_ff @(posedge clock_in) begin
    if (rst_in || mode_q != cpmbt_pkg::MODE_WAIT) begin
      idle_cnt_q <= 4'h0;
    end else if (bt_samp && !bt_bit) begin
      idle_cnt_q <= 4'h0;
    end else if (bt_samp && idle_cnt_q != `CPMBT_IDLE_BITS) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign cfg = '{presc: {pext_q, bt0_q[`CPMBT_BT0_PRESC]}, resync_jump_width: bt0_q[`CPMBT_BT0_SJW],
                 seg1: bt1_q[`CPMBT_BT1_SEG1], seg2: bt1_q[`CPMBT_BT1_SEG2],
                 triple: bt1_q[`CPMBT_BT1_TRIPLE]};

  cpmbt_bit_timer u_bit_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .enable_in(bt_en),
    .rx_in(rx_s_q),
    .cfg_in(cfg),
    .tx_point_out(bt_tx),
    .sample_point_out(bt_samp),
    .sample_bit_out(bt_bit)
  );

  always_ff @(posedge clock_in) begin
    if (rst_in || !run_d) begin
      tx_q <= 1'b1;
    end else if (bt_tx) begin
      tx_q <= eng_tx_bit_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bs_q <= 1'b0;
      smp_q <= 1'b0;
      rxb_q <= 1'b1;
    end else begin
      bs_q <= run_d & bt_tx;
      smp_q <= run_d & bt_samp;
      if (bt_samp) begin
        rxb_q <= bt_bit;
      end
    end
  end

  // Pulse runs from the frame-ok strobe to the next sample point; the set wins.
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_d) begin
      pulse_q <= 1'b0;
    end else if (eng_frame_ok_in) begin
      pulse_q <= 1'b1;
    end else if (bt_samp) begin
      pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tmr_q <= 1'b0;
    end else begin
      tmr_q <= pulse_q & tlnk_q;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign can_tx_pin_out = tx_q;
  assign eng_tx_data_out = txd_q;
  assign eng_run_out = run_q;
  assign eng_bit_start_out = bs_q;
  assign eng_sample_out = smp_q;
  assign eng_rx_bit_out = rxb_q;
  assign timer_b_ch0_out = tmr_q;
  assign wake_mcu_out = wake_q;
  assign clock_source_out = clock_source_select_q;

  ////////////////////////////////////////////////////////////////////////////////
  srst_halt_a: assert property (@(posedge clock_in) disable iff (rst_in)
    srst_q |=> !eng_run_out && can_tx_pin_out) else $error("run or drive during soft reset");
  stop_halt_a: assert property (@(posedge clock_in) disable iff (rst_in)
    stop_mode_in |=> !eng_run_out) else $error("engine runs in power-down");
  stop_recessive_a: assert property (@(posedge clock_in) disable iff (rst_in)
    stop_mode_in |=> can_tx_pin_out) else $error("tx pin dominant in power-down");
  stop_noaccess_a: assert property (@(posedge clock_in) disable iff (rst_in)
    pready_out && $past(stop_mode_in) |-> pslverr_out && prdata_out == 32'h00000000)
    else $error("register reached in power-down");
  cfg_open_a: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_ok && srst_q && idx == `CPMBT_IDX_BT1 |=> bt1_q == $past(pwdata_in[7:0]))
    else $error("timing write lost in soft reset");
  cfg_lock_a: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_ok && !srst_q |=> $stable(bt1_q) && $stable(bt0_q) && $stable(clock_source_select_q))
    else $error("locked register changed");
  idle_wait_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(eng_run_out) |-> $past(idle_cnt_q) == `CPMBT_IDLE_BITS) else $error("joined bus early");
  tx_point_a: assert property (@(posedge clock_in) disable iff (rst_in)
    run_d && bt_tx |=> can_tx_pin_out == $past(eng_tx_bit_in)) else $error("tx bit not driven");
  pulse_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    pulse_q && !bt_samp && run_d |=> pulse_q) else $error("frame pulse cut short");
  timer_link_a: assert property (@(posedge clock_in) disable iff (rst_in)
    timer_b_ch0_out |-> $past(tlnk_q) && $past(pulse_q)) else $error("timer link without enable");
  wake_filter_a: assert property (@(posedge clock_in) disable iff (rst_in)
    wake_mcu_out |-> $past(wcnt_q) == (wake_filter_mode_q ? 8'(WAKE_FILT_CYC) : 8'h01)) else $error("wake unfiltered");
endmodule // cpmbt_top

// ===== bench/cpmbt_bus_node.sv
`timescale 1ns/1ps
module cpmbt_bus_node (
  input wire logic clock_in, // module clock
  input wire logic tx_in, // controller transmit pin
  input wire logic dom_in, // far node drives dominant
  output logic rx_out // resolved bus level
);
  logic dom_q;
  always_ff @(posedge clock_in) begin
    dom_q <= dom_in;
  end
  // The bus is wired-AND over a recessive pull-up, so any dominant driver wins.
  assign rx_out = tx_in & ~dom_q;
endmodule // cpmbt_bus_node

// ===== bench/can_power_modes_bit_timing_bench.sv
`timescale 1ns/1ps
`include "cpmbt_regs.svh"
module can_power_modes_bit_timing_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel, penable, pwrite, stop, rx, tx, tx_bit, fok, rx_we, dom;
  logic pready, pslverr, err, run, bs, sp, tmr, wake, csrc, rxb, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] rx_addr;
  logic [7:0] rx_data, txd, b0, b1;
  logic [5:0] tx_addr;
  int n_errors = 0;
  int checked = 0;
  int seed = 32'hff45d11b;
  int cyc = 0;
  int n, p, c;
  cpmbt_top i_cpmbt_top (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .stop_mode_in(stop), .can_rx_pin_in(rx), .can_tx_pin_out(tx),
    .eng_tx_bit_in(tx_bit), .eng_busy_in(busy), .eng_frame_ok_in(fok), .eng_rx_we_in(rx_we),
    .eng_rx_addr_in(rx_addr), .eng_rx_data_in(rx_data), .eng_tx_addr_in(tx_addr), .eng_tx_data_out(txd),
    .eng_run_out(run), .eng_bit_start_out(bs), .eng_sample_out(sp), .eng_rx_bit_out(rxb),
    .timer_b_ch0_out(tmr), .wake_mcu_out(wake), .clock_source_out(csrc));
  cpmbt_bus_node i_cpmbt_bus_node (.clock_in(clock_in), .tx_in(tx), .dom_in(dom), .rx_out(rx));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Ready is read at the edge itself, so data capture and release fall on the completion edge.
  task apb(input logic wr, input logic [6:0] idx, input logic [7:0] d, input logic [2:0] hi);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {hi, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string what, input logic [6:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 3'h0);
    chk(what, {24'h0, exp}, rd);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? bs : s == 1 ? sp : s == 2 ? run : s == 3 ? wake : tmr;
  endfunction
  task waitfor(input int s, output int k);
    k = 0;
    do begin
      @(posedge clock_in);
      #1;
      k++;
    end while (pick(s) !== 1'b1 && k < 3000);
  endtask
  task scan(input int s, input int len, output int seen);
    seen = 0;
    repeat (len) begin
      @(posedge clock_in);
      #1;
      if (pick(s) === 1'b1) seen++;
    end
  endtask
  function automatic int bit_cycles(input logic [7:0] t0, input logic [7:0] t1);
    int s1, s2;
    s1 = t1[3:0] < 3 ? 3 : int'(t1[3:0]);
    s2 = t1[6:4] < 1 ? 1 : int'(t1[6:4]);
    return (int'(t0[5:0]) + 1) * (s1 + s2 + 3);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    {psel, penable, pwrite, stop, fok, rx_we, dom, busy, paddr, pwdata, rx_addr, rx_data, tx_addr} = '0;
    tx_bit = 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    rdchk("control0 reset", `CPMBT_IDX_CTRL0, 8'h01);
    apb(1'b0, 7'h00, 8'h00, 3'h4);
    chk("unmapped error", 32'h1, {31'h0, err});
    rdchk("reserved", 7'h18, 8'h00);
    apb(1'b1, `CPMBT_IDX_CTRL1, 8'h03, 3'h0);
    rdchk("control1", `CPMBT_IDX_CTRL1, 8'h03);
    chk("clock source", 32'h1, {31'h0, csrc});
    n = $random(seed);
    apb(1'b1, {4'h2, n[18:16]}, n[31:24], 3'h0);
    rdchk("filter byte", {4'h2, n[18:16]}, n[31:24]);
    apb(1'b1, {3'h5, n[3:0]}, n[15:8], 3'h0);
    tx_addr <= {2'h0, n[3:0]};
    rx_we <= 1'b1;
    rx_addr <= 4'h5;
    rx_data <= n[23:16];
    repeat (2) @(posedge clock_in);
    rx_we <= 1'b0;
    #1;
    chk("transmit buffer", {24'h0, n[15:8]}, {24'h0, txd});
    rdchk("receive buffer", 7'h45, n[23:16]);
    for (int k = 0; k < 3; k++) begin
      n = $random(seed);
      b0 = k == 0 ? 8'h00 : k == 1 ? 8'hc0 : {n[7:6], 4'h0, n[9:8]};
      b1 = k == 0 ? 8'h02 : k == 1 ? 8'hff : {n[16], n[14:12], n[11:8]};
      if (k == 2) begin
        // Park the controller in sleep before soft reset; a busy engine holds sleep off.
        busy <= 1'b1;
        apb(1'b1, `CPMBT_IDX_CTRL0, 8'h0a, 3'h0);
        rdchk("sleep held off", `CPMBT_IDX_CTRL0, 8'h1a);
        busy <= 1'b0;
        rdchk("sleep acknowledge", `CPMBT_IDX_CTRL0, 8'h0e);
      end
      apb(1'b1, `CPMBT_IDX_CTRL0, 8'h01, 3'h0);
      @(posedge clock_in);
      #1;
      chk("run in soft reset", 32'h0, {31'h0, run});
      apb(1'b1, `CPMBT_IDX_BT0, b0, 3'h0);
      apb(1'b1, `CPMBT_IDX_BT1, b1, 3'h0);
      rdchk("timing 1", `CPMBT_IDX_BT1, b1);
      apb(1'b1, `CPMBT_IDX_CTRL0, 8'h08, 3'h0);
      n = 0;
      p = 0;
      do begin
        @(posedge clock_in);
        #1;
        if (sp === 1'b1) n++;
        p++;
      end while (run !== 1'b1 && p < 3000);
      chk("samples before run", 32'd0, n);
      chk("join delay", 32'h1, {31'h0, p >= 10 * bit_cycles(b0, b1) && p <= 11 * bit_cycles(b0, b1)});
      waitfor(0, c);
      waitfor(0, c);
      chk("bit period", bit_cycles(b0, b1), c);
      waitfor(1, c);
      waitfor(1, c);
      chk("sample period", bit_cycles(b0, b1), c);
      apb(1'b1, `CPMBT_IDX_BT1, ~b1, 3'h0);
      rdchk("timing 1 locked", `CPMBT_IDX_BT1, b1);
    end
    tx_bit <= 1'b0;
    waitfor(0, c);
    waitfor(0, c);
    chk("dominant bit", 32'h0, {31'h0, tx});
    chk("sampled dominant", 32'h0, {31'h0, rxb});
    tx_bit <= 1'b1;
    waitfor(0, c);
    chk("recessive bit", 32'h1, {31'h0, tx});
    // Frame end is raised in the cycle of a sample point, as at the close of a real frame.
    waitfor(1, c);
    repeat (bit_cycles(b0, b1) - 1) @(posedge clock_in);
    fok <= 1'b1;
    @(posedge clock_in);
    fok <= 1'b0;
    waitfor(4, p);
    chk("timer latency", 32'd1, p);
    scan(4, bit_cycles(b0, b1) + 2, n);
    chk("timer width", bit_cycles(b0, b1), n + 1);
    chk("sampled recessive", 32'h1, {31'h0, rxb});
    apb(1'b1, `CPMBT_IDX_CTRL0, 8'h00, 3'h0);
    fok <= 1'b1;
    @(posedge clock_in);
    fok <= 1'b0;
    scan(4, bit_cycles(b0, b1), n);
    chk("timer unlinked", 32'h0, n);
    stop <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    chk("tx in power-down", 32'h1, {31'h0, tx});
    chk("run in power-down", 32'h0, {31'h0, run});
    apb(1'b0, `CPMBT_IDX_CTRL0, 8'h00, 3'h0);
    chk("power-down access", 32'h1, {31'h0, err});
    dom <= 1'b1;
    repeat (5) @(posedge clock_in);
    dom <= 1'b0;
    scan(3, 20, n);
    chk("glitch wake", 32'h0, n);
    dom <= 1'b1;
    scan(3, 30, n);
    dom <= 1'b0;
    chk("bus wake", 32'h1, n);
    stop <= 1'b0;
    waitfor(2, c);
    rdchk("control0 resynced", `CPMBT_IDX_CTRL0, 8'h10);
    results;
  end
endmodule // can_power_modes_bit_timing_bench
